// [logic/gpio_query_pkg.sv]
package gpio_query_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLOCK_HZ      = 100_000_000;
  localparam int unsigned SAMPLE_HZ     = 32;
  localparam int unsigned SAMPLE_CYCLES = CLOCK_HZ / SAMPLE_HZ;

  // ==========================================================================
  // Pins and query
  localparam int unsigned PIN_COUNT  = 13;
  localparam int unsigned GPIO_COUNT = 5;
  localparam logic [7:0]  QUERY_TYPE = 8'h23;
  localparam logic [7:0]  DUTY_MAX   = 8'h64;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_CMD   = 8'h00;
  localparam logic [7:0] OFF_REPLY = 8'h04;
  localparam logic [7:0] OFF_QSTAT = 8'h08;
  localparam logic [7:0] OFF_CFG   = 8'h0c;
  localparam logic [7:0] OFF_IST   = 8'h10;
  localparam logic [7:0] OFF_ICLR  = 8'h14;
  localparam logic [7:0] OFF_IEN   = 8'h18;
  localparam logic [7:0] OFF_PINS  = 8'h1c;

  // ==========================================================================
  // Field positions
  localparam int unsigned CMD_SEL_LSB  = 0;
  localparam int unsigned CMD_TYPE_LSB = 8;
  localparam int unsigned CFG_PIN_LSB  = 0;
  localparam int unsigned CFG_DUTY_LSB = 8;
  localparam int unsigned CFG_DRV_LSB  = 16;
  localparam int unsigned CFG_FUNC_BIT = 19;
  localparam int unsigned IRQ_REPLY    = 0;
  localparam int unsigned IRQ_ERROR    = 1;
  localparam int unsigned IRQ_EDGE     = 2;
  localparam int unsigned IRQ_BITS     = 3;

  // ==========================================================================
  // Reset values and bus answers
  localparam logic [2:0]  IEN_RESET   = 3'h0;
  localparam logic [11:0] CFG_RESET   = 12'h000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic       func;
    logic [2:0] drive;
    logic [7:0] duty;
  } pin_cfg_t;

  typedef struct packed {
    logic [7:0] cfgByte;
    logic [7:0] duty;
    logic [7:0] stateByte;
    logic [7:0] sel;
  } reply_t;

  typedef enum logic [2:0] {
    Q_IDLE  = 3'b001,
    Q_FETCH = 3'b010,
    Q_FORM  = 3'b100
  } query_state_t;

endpackage

// [logic/pin_cfg_mem.sv]
`timescale 1ns/10ps
module pin_cfg_mem #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 13
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);

  // ==========================================================================
  // Storage with registered read
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= gpio_query_pkg::CFG_RESET;
      end
      rdData <= gpio_query_pkg::CFG_RESET;
    end else begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
    end
  end

endmodule // pin_cfg_mem

// [logic/pin_sampler.sv]
`timescale 1ns/10ps
module pin_sampler #(
  parameter int unsigned PINS          = 5,
  parameter int unsigned SAMPLE_CYCLES = 3125000
) (
  input  wire logic            clock,
  input  wire logic            rst,
  input  wire logic [PINS-1:0] pinLevel,
  input  wire logic [PINS-1:0] flagClear,
  output logic      [PINS-1:0] level,
  output logic      [PINS-1:0] rise,
  output logic      [PINS-1:0] fall,
  output logic                 edgeEvent
);

  localparam int unsigned CW = $clog2(SAMPLE_CYCLES);

  // ==========================================================================
  // Free-running sample tick
  logic [CW-1:0] cnt_reg;
  logic          primed_reg;
  wire           tick     = (cnt_reg == CW'(SAMPLE_CYCLES - 1));
  wire [PINS-1:0] newRise = (tick && primed_reg) ? (pinLevel & ~level) : '0;
  wire [PINS-1:0] newFall = (tick && primed_reg) ? (~pinLevel & level) : '0;

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= tick ? '0 : cnt_reg + CW'(1);
    end
  end

  // ==========================================================================
  // Level and sticky edge flags
  always_ff @(posedge clock) begin
    if (rst) begin
      primed_reg <= 1'b0;
      level      <= '0;
      rise       <= '0;
      fall       <= '0;
      edgeEvent  <= 1'b0;
    end else begin
      if (tick) begin
        primed_reg <= 1'b1;
        level      <= pinLevel;
      end
      rise      <= (rise & ~flagClear) | newRise;
      fall      <= (fall & ~flagClear) | newFall;
      edgeEvent <= |(newRise | newFall);
    end
  end

endmodule // pin_sampler

// [logic/gpio_level_config_readback.sv]
// Operation
// - Query is type 0x23 with one selector byte
// - Selectors 13 to 255 name no pin
// - Reply byte zero echoes the selector
// - State byte zero for output-only pins
// - State bit0 is last sampled level
// - State bit1 marks a sampled falling edge
// - State bit2 marks a sampled rising edge
// - Level is the real pin, not setting
// - Pins sampled free-running at about 32 Hz
// - Pulses between samples may go unseen
// - Byte two returns requested duty 0-100
// - Byte three low bits give drive mode
// - Byte three bit3 gives function select
// - Function bit zero for output-only pins
// - Upper function byte bits return zero
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module gpio_level_config_readback #(
  parameter int unsigned SAMPLE_CYCLES = gpio_query_pkg::SAMPLE_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [4:0]  pinLevel,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);

  localparam int unsigned NP = gpio_query_pkg::PIN_COUNT;
  localparam int unsigned NG = gpio_query_pkg::GPIO_COUNT;
  localparam int unsigned AW = $clog2(NP);

  // ==========================================================================
  // Helpers
  function automatic logic isOff(input logic [7:0] addr, input logic [7:0] off);
    isOff = (addr[7:2] == off[7:2]);
  endfunction

  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = isOff(addr, gpio_query_pkg::OFF_CMD)   ||
               isOff(addr, gpio_query_pkg::OFF_REPLY) ||
               isOff(addr, gpio_query_pkg::OFF_QSTAT) ||
               isOff(addr, gpio_query_pkg::OFF_CFG)   ||
               isOff(addr, gpio_query_pkg::OFF_IST)   ||
               isOff(addr, gpio_query_pkg::OFF_ICLR)  ||
               isOff(addr, gpio_query_pkg::OFF_IEN)   ||
               isOff(addr, gpio_query_pkg::OFF_PINS);
  endfunction

  // ==========================================================================
  // Write channel capture
  logic [7:0]  awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        awHave_reg;
  logic        wHave_reg;

  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake  = s_axi_wvalid && s_axi_wready;
  wire bDone  = s_axi_bvalid && s_axi_bready;
  wire wrHit  = awHave_reg && wHave_reg && !s_axi_bvalid;

  always_ff @(posedge clock) begin
    if (rst) begin
      awAddr_reg    <= 8'h00;
      awHave_reg    <= 1'b0;
      s_axi_awready <= 1'b1;
    end else begin
      if (awTake) begin
        awAddr_reg    <= s_axi_awaddr;
        awHave_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (wrHit) begin
        awHave_reg <= 1'b0;
      end else if (bDone) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wData_reg    <= 32'h0000_0000;
      wStrb_reg    <= 4'h0;
      wHave_reg    <= 1'b0;
      s_axi_wready <= 1'b1;
    end else begin
      if (wTake) begin
        wData_reg    <= s_axi_wdata;
        wStrb_reg    <= s_axi_wstrb;
        wHave_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (wrHit) begin
        wHave_reg <= 1'b0;
      end else if (bDone) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Write response
  wire [1:0] wrResp = isMapped(awAddr_reg) ? gpio_query_pkg::RESP_OKAY : gpio_query_pkg::RESP_SLVERR;

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gpio_query_pkg::RESP_OKAY;
    end else if (wrHit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrResp;
    end else if (bDone) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Write decode
  wire lowLane = wStrb_reg[0];

  wire wrCmd   = wrHit && lowLane && isOff(awAddr_reg, gpio_query_pkg::OFF_CMD);
  wire wrCfg   = wrHit && lowLane && isOff(awAddr_reg, gpio_query_pkg::OFF_CFG);
  wire wrIclr  = wrHit && lowLane && isOff(awAddr_reg, gpio_query_pkg::OFF_ICLR);
  wire wrIen   = wrHit && lowLane && isOff(awAddr_reg, gpio_query_pkg::OFF_IEN);

  wire [7:0] cmdSel  = wData_reg[gpio_query_pkg::CMD_SEL_LSB +: 8];
  wire [7:0] cmdType = wData_reg[gpio_query_pkg::CMD_TYPE_LSB +: 8];
  wire [7:0] cfgPin  = wData_reg[gpio_query_pkg::CFG_PIN_LSB +: 8];
  wire [7:0] cfgDuty = wData_reg[gpio_query_pkg::CFG_DUTY_LSB +: 8];
  wire [2:0] cfgDrv  = wData_reg[gpio_query_pkg::CFG_DRV_LSB +: 3];
  wire       cfgFunc = wData_reg[gpio_query_pkg::CFG_FUNC_BIT];

  wire cfgOk  = (cfgPin < 8'(NP)) && (cfgDuty <= gpio_query_pkg::DUTY_MAX);
  wire cfgBad = wrCfg && !cfgOk;

  gpio_query_pkg::pin_cfg_t cfgWord;
  assign cfgWord.func  = cfgFunc;
  assign cfgWord.drive = cfgDrv;
  assign cfgWord.duty  = cfgDuty;

  // ==========================================================================
  // Query sequencer
  gpio_query_pkg::query_state_t state_reg;
  gpio_query_pkg::query_state_t state_next;
  logic [7:0]                   sel_reg;
  logic [7:0]                   cmdSel_reg;
  logic [7:0]                   cmdType_reg;

  wire cmdIsQuery = (cmdType == gpio_query_pkg::QUERY_TYPE);
  wire cmdStart   = wrCmd && cmdIsQuery && (state_reg == gpio_query_pkg::Q_IDLE);
  wire cmdBad     = wrCmd && !cmdStart;

  wire selPin     = (sel_reg < 8'(NP));
  wire selGpio    = (sel_reg < 8'(NG));

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      gpio_query_pkg::Q_IDLE: begin
        if (cmdStart) begin
          state_next = gpio_query_pkg::Q_FETCH;
        end
      end
      gpio_query_pkg::Q_FETCH: begin
        state_next = gpio_query_pkg::Q_FORM;
      end
      gpio_query_pkg::Q_FORM: begin
        state_next = gpio_query_pkg::Q_IDLE;
      end
      default: begin
        state_next = gpio_query_pkg::Q_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg   <= gpio_query_pkg::Q_IDLE;
      sel_reg     <= 8'h00;
      cmdSel_reg  <= 8'h00;
      cmdType_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (wrCmd) begin
        cmdSel_reg  <= cmdSel;
        cmdType_reg <= cmdType;
      end
      if (cmdStart) begin
        sel_reg <= cmdSel;
      end
    end
  end

  wire forming = (state_reg == gpio_query_pkg::Q_FORM);
  wire busy    = (state_reg != gpio_query_pkg::Q_IDLE);

  // ==========================================================================
  // Pin configuration store
  gpio_query_pkg::pin_cfg_t cfgRead;

  pin_cfg_mem #(
    .WIDTH ($bits(gpio_query_pkg::pin_cfg_t)),
    .DEPTH (NP)
  ) u_cfg (
    .clock  (clock),
    .rst    (rst),
    .wrEn   (wrCfg && cfgOk),
    .wrAddr (cfgPin[AW-1:0]),
    .wrData (cfgWord),
    .rdAddr (sel_reg[AW-1:0]),
    .rdData (cfgRead)
  );

  // ==========================================================================
  // Pin sampling
  logic [NG-1:0] lvl;
  logic [NG-1:0] rise;
  logic [NG-1:0] fall;
  logic          edgeEvent;

  wire  [NG-1:0] selMask = NG'(1) << sel_reg[2:0];
  wire  [NG-1:0] clrMask = (forming && selGpio) ? selMask : '0;

  pin_sampler #(
    .PINS          (NG),
    .SAMPLE_CYCLES (SAMPLE_CYCLES)
  ) u_samp (
    .clock     (clock),
    .rst       (rst),
    .pinLevel  (pinLevel),
    .flagClear (clrMask),
    .level     (lvl),
    .rise      (rise),
    .fall      (fall),
    .edgeEvent (edgeEvent)
  );

  // ==========================================================================
  // Reply assembly
  wire [2:0] pinFlags  = {rise[sel_reg[2:0]], fall[sel_reg[2:0]], lvl[sel_reg[2:0]]};

  wire [7:0] stateByte = selGpio ? {5'h00, pinFlags} : 8'h00;
  wire       funcBit   = selGpio ? cfgRead.func : 1'b0;
  wire [7:0] cfgByte   = selPin ? {4'h0, funcBit, cfgRead.drive} : 8'h00;
  wire [7:0] dutyByte  = selPin ? cfgRead.duty : 8'h00;

  gpio_query_pkg::reply_t reply_reg;
  logic                   replyBad_reg;

  always_ff @(posedge clock) begin
    if (rst) begin
      reply_reg    <= '0;
      replyBad_reg <= 1'b0;
    end else if (forming) begin
      reply_reg.sel       <= sel_reg;
      reply_reg.stateByte <= stateByte;
      reply_reg.duty      <= dutyByte;
      reply_reg.cfgByte   <= cfgByte;
      replyBad_reg        <= !selPin;
    end
  end

  // ==========================================================================
  // Interrupts
  logic [gpio_query_pkg::IRQ_BITS-1:0] ist_reg;
  logic [gpio_query_pkg::IRQ_BITS-1:0] ien_reg;
  logic [gpio_query_pkg::IRQ_BITS-1:0] events;
  logic [gpio_query_pkg::IRQ_BITS-1:0] istClr;
  logic [gpio_query_pkg::IRQ_BITS-1:0] ist_next;

  assign events[gpio_query_pkg::IRQ_REPLY] = forming;
  assign events[gpio_query_pkg::IRQ_ERROR] = cmdBad || cfgBad || (forming && !selPin);
  assign events[gpio_query_pkg::IRQ_EDGE]  = edgeEvent;

  assign istClr   = wrIclr ? wData_reg[gpio_query_pkg::IRQ_BITS-1:0] : '0;
  assign ist_next = (ist_reg & ~istClr) | events;

  always_ff @(posedge clock) begin
    if (rst) begin
      ist_reg <= '0;
      ien_reg <= gpio_query_pkg::IEN_RESET;
      irq     <= 1'b0;
    end else begin
      ist_reg <= ist_next;
      if (wrIen) begin
        ien_reg <= wData_reg[gpio_query_pkg::IRQ_BITS-1:0];
      end
      irq <= |(ist_next & (wrIen ? wData_reg[gpio_query_pkg::IRQ_BITS-1:0] : ien_reg));
    end
  end

  // ==========================================================================
  // Read path
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire rDone  = s_axi_rvalid && s_axi_rready;

  wire [1:0] rdResp = isMapped(s_axi_araddr) ? gpio_query_pkg::RESP_OKAY : gpio_query_pkg::RESP_SLVERR;

  wire [31:0] rdCmd   = {16'h0000, cmdType_reg, cmdSel_reg};
  wire [31:0] rdQstat = {30'h0, replyBad_reg, busy};
  wire [31:0] rdPins  = {17'h0, rise, fall, lvl};
  wire [31:0] rdIst   = {29'h0, ist_reg};
  wire [31:0] rdIen   = {29'h0, ien_reg};

  wire [31:0] readData =
    isOff(s_axi_araddr, gpio_query_pkg::OFF_CMD)   ? rdCmd     :
    isOff(s_axi_araddr, gpio_query_pkg::OFF_REPLY) ? reply_reg :
    isOff(s_axi_araddr, gpio_query_pkg::OFF_QSTAT) ? rdQstat   :
    isOff(s_axi_araddr, gpio_query_pkg::OFF_IST)   ? rdIst     :
    isOff(s_axi_araddr, gpio_query_pkg::OFF_IEN)   ? rdIen     :
    isOff(s_axi_araddr, gpio_query_pkg::OFF_PINS)  ? rdPins    :
    32'h0000_0000;

  always_ff @(posedge clock) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= gpio_query_pkg::RESP_OKAY;
    end else if (arTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= readData;
      s_axi_rresp   <= rdResp;
    end else if (rDone) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

endmodule // gpio_level_config_readback

// [verification/gpio_query_monitor.sv]
`timescale 1ns/10ps
module gpio_query_monitor #(
  parameter int unsigned SAMPLE_CYCLES = 16
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic replyRead;
  logic arTaken;
  assign arTaken   = s_axi_arvalid && s_axi_arready;
  assign replyRead = arTaken && s_axi_araddr == gpio_query_pkg::OFF_REPLY;
  // ====================
  // Bus timing
  a_write_answer: assert property (
    (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during answer");
  a_read_answer: assert property (arTaken |=> s_axi_rvalid)
    else $error("read answer missing");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read ready during answer");
  a_unmapped_read: assert property ((arTaken && s_axi_araddr >= 8'h20) |=>
    s_axi_rresp == gpio_query_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  // ====================
  // Reply fields
  a_reply_upper_zero: assert property (
    replyRead |=> s_axi_rdata[31:28] == 4'h0) else $error("reserved bits set");
  a_output_state_zero: assert property (
    replyRead |=> s_axi_rdata[7:0] < 8'h05 || s_axi_rdata[15:8] == 8'h00) else $error("output pin state");
  a_output_func_zero: assert property (
    replyRead |=> s_axi_rdata[7:0] < 8'h05 || !s_axi_rdata[27]) else $error("output pin function");
  a_duty_range: assert property (
    replyRead |=> s_axi_rdata[23:16] <= gpio_query_pkg::DUTY_MAX) else $error("duty out of range");
  a_reserved_sel: assert property (
    replyRead |=> s_axi_rdata[7:0] < 8'h0d || s_axi_rdata[31:8] == 24'h0) else $error("reserved reply");
  c_reply_read: cover property (replyRead ##1 s_axi_rdata[15:8] != 8'h00);
  c_unmapped: cover property (arTaken && s_axi_araddr >= 8'h20);
  c_irq: cover property ($rose(irq));
endmodule // gpio_query_monitor

bind gpio_level_config_readback gpio_query_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) monitor (
  .clock, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .irq
);

// [verification/host_link_model.sv]
`timescale 1ns/10ps
module host_link_model (
  input  wire logic        clock,
  output logic      [7:0]  s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic [1:0]  s_axi_bresp,
  output logic      [7:0]  s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic [31:0] s_axi_rdata
);
  initial begin
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0;
    s_axi_wvalid  = 1'b0;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'b0;
  end
  // ====================
  // Bus cycles
  task automatic busWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        break;
      end
    end
  endtask
  task automatic busRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
  endtask
  // Query with one selector byte, then wait for the reply
  task automatic query(input logic [7:0] sel, output logic [31:0] reply);
    logic [1:0]  r;
    logic [31:0] st;
    busWrite(gpio_query_pkg::OFF_CMD, {16'h0000, gpio_query_pkg::QUERY_TYPE, sel}, r);
    st = 32'h1;
    while (st[0]) busRead(gpio_query_pkg::OFF_QSTAT, st, r);
    busRead(gpio_query_pkg::OFF_REPLY, reply, r);
  endtask
endmodule // host_link_model

// [verification/testbench.sv]
`timescale 1ns/10ps
`define CHECK(N, E, G) begin nTests++; if ((G) !== (E)) begin numErrors++; $display("unexpected %s: expected %h, seen %h", N, E, G); end end
module testbench;
  logic        clock, rst, irq;
  logic [4:0]  pinLevel, lvl, riseSeen, fallSeen, lv;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rnd, rnd2;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  duty [13];
  logic [2:0]  drive [13];
  logic        func [13];
  integer      seed, cycles, numErrors, nTests, i, k;

  gpio_level_config_readback #(.SAMPLE_CYCLES(16)) uut (
    .clock, .rst, .pinLevel, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready(1'b1), .irq
  );
  host_link_model host (
    .clock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rresp, .s_axi_rdata
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      numErrors++;
      conclude();
    end
  end
  // ====================
  // Expectations and helpers
  function automatic gpio_query_pkg::reply_t expectReply(input logic [7:0] s);
    gpio_query_pkg::reply_t r;
    r = '0;
    r.sel = s;
    if (s < 8'h0d) begin
      r.duty    = duty[s];
      r.cfgByte = {5'h00, drive[s]};
      if (s < 8'h05) begin
        r.stateByte  = {5'h00, riseSeen[s], fallSeen[s], lvl[s]};
        r.cfgByte[3] = func[s];
      end
    end
    return r;
  endfunction
  task automatic expectReg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                           input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    host.busRead(a, d, r);
    `CHECK("register", e, d & m)
    `CHECK("response", er, r)
  endtask
  task automatic setPin(input logic [7:0] p, input logic [7:0] d, input logic [2:0] m, input logic f);
    host.busWrite(gpio_query_pkg::OFF_CFG, {12'h000, f, m, d, p}, resp);
    `CHECK("bresp", gpio_query_pkg::RESP_OKAY, resp)
    if (p < 8'h0d && d <= gpio_query_pkg::DUTY_MAX) begin
      duty[p]  = d;
      drive[p] = m;
      func[p]  = f;
    end
  endtask
  task automatic checkQuery(input logic [7:0] s);
    logic [31:0] got;
    host.query(s, got);
    `CHECK("reply", expectReply(s), got)
    if (s < 8'h05) begin
      riseSeen[s] = 1'b0;
      fallSeen[s] = 1'b0;
    end
  endtask
  task automatic settle(input logic e);
    repeat (2) @(posedge clock);
    `CHECK("irq", e, irq)
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ====================
  // Main sequence
  initial begin
    seed = 32'h952b;
    rst = 1'b1;
    pinLevel = 5'h00;
    cycles = 0;
    numErrors = 0;
    nTests = 0;
    lvl = 5'h00;
    riseSeen = 5'h00;
    fallSeen = 5'h00;
    for (i = 0; i < 13; i++) begin
      duty[i] = 8'h00;
      drive[i] = 3'h0;
      func[i] = 1'b0;
    end
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    expectReg(gpio_query_pkg::OFF_IEN, 32'hffffffff, 32'h0, gpio_query_pkg::RESP_OKAY);
    expectReg(8'h40, 32'hffffffff, 32'h0, gpio_query_pkg::RESP_SLVERR);
    host.busWrite(8'h40, 32'h0, resp);
    `CHECK("bresp", gpio_query_pkg::RESP_SLVERR, resp)
    expectReg(gpio_query_pkg::OFF_CFG, 32'hffffffff, 32'h0, gpio_query_pkg::RESP_OKAY);
    $display("test registers done");
    for (i = 0; i < 13; i++) begin
      rnd = {$random(seed)} % 101;
      rnd2 = $random(seed);
      setPin(i[7:0], rnd[7:0], rnd2[2:0], rnd2[3]);
    end
    setPin(8'h03, 8'h64, 3'h7, 1'b1);
    setPin(8'h06, 8'h00, 3'h6, 1'b1);
    setPin(8'h0d, 8'h10, 3'h1, 1'b1);
    setPin(8'h02, 8'h65, 3'h1, 1'b1);
    $display("test settings done");
    for (k = 0; k < 10; k++) begin
      rnd = $random(seed);
      lv = (k == 0) ? 5'h1f : (k < 3) ? 5'h00 : rnd[4:0];
      pinLevel <= lv;
      repeat (40) @(posedge clock);
      riseSeen = riseSeen | (lv & ~lvl);
      fallSeen = fallSeen | (lvl & ~lv);
      lvl = lv;
      if (k > 0) for (i = 0; i < 13; i++) checkQuery(i[7:0]);
    end
    expectReg(gpio_query_pkg::OFF_QSTAT, 32'h2, 32'h0, gpio_query_pkg::RESP_OKAY);
    expectReg(gpio_query_pkg::OFF_PINS, 32'h7fff, {27'h0, lvl}, gpio_query_pkg::RESP_OKAY);
    expectReg(gpio_query_pkg::OFF_IST, 32'h4, 32'h4, gpio_query_pkg::RESP_OKAY);
    $display("test readback done");
    for (k = 0; k < 6; k++) begin
      rnd = (k == 0) ? 32'hff : (k == 1) ? 32'h0d : 32'h0d + {$random(seed)} % 243;
      checkQuery(rnd[7:0]);
      expectReg(gpio_query_pkg::OFF_QSTAT, 32'h2, 32'h2, gpio_query_pkg::RESP_OKAY);
    end
    $display("test reserved done");
    host.busWrite(gpio_query_pkg::OFF_ICLR, 32'h7, resp);
    host.busWrite(gpio_query_pkg::OFF_CMD, {16'h0000, 8'h22, 8'h00}, resp);
    expectReg(gpio_query_pkg::OFF_IST, 32'h2, 32'h2, gpio_query_pkg::RESP_OKAY);
    expectReg(gpio_query_pkg::OFF_QSTAT, 32'h1, 32'h0, gpio_query_pkg::RESP_OKAY);
    $display("test command type done");
    host.busWrite(gpio_query_pkg::OFF_ICLR, 32'h7, resp);
    host.busWrite(gpio_query_pkg::OFF_IEN, 32'h1, resp);
    settle(1'b0);
    checkQuery(8'h00);
    settle(1'b1);
    host.busWrite(gpio_query_pkg::OFF_IEN, 32'h0, resp);
    settle(1'b0);
    host.busWrite(gpio_query_pkg::OFF_IEN, 32'h1, resp);
    settle(1'b1);
    expectReg(gpio_query_pkg::OFF_IEN, 32'h7, 32'h1, gpio_query_pkg::RESP_OKAY);
    host.busWrite(gpio_query_pkg::OFF_ICLR, 32'h1, resp);
    settle(1'b0);
    expectReg(gpio_query_pkg::OFF_IST, 32'h1, 32'h0, gpio_query_pkg::RESP_OKAY);
    $display("test interrupt done");
    conclude();
  end
endmodule // testbench
